// ===== design/lst_top.sv
// link sync source select, link start sequencing and sample marking
//
// Behaviour
// - read-out pin undriven except while a serial register read runs
// - select 0 uses the single-ended active-low sync pin in 8b/10b
// - 64b/66b link ignores sync for start; sync may trigger nco sync
// - low sync request starts code group synchronisation in 8b/10b
// - sync release after code group sync starts lane alignment sequence
// - select 1 takes sync from the differential marker pair instead
// - marker pair used as sync is active low like the pin
// - mark enable 1 flags the sample taken while marker is asserted
// - marker pair may serve as sync and sample marker at once
// - marker pair ignored unless its receiver enable is 1
`timescale 1ns/1ps
`include "lst_cfg.svh"
module lst_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // configuration
    input wire logic sync_sel_i,
    input wire logic mode_64b66b_i,
    input wire logic marker_pair_receiver_enable_i,
    input wire logic sample_mark_enable_i,
    // sync and marker pins
    input wire logic single_ended_sync_pin_n_i,
    input wire logic marker_pair_input_p_i,
    input wire logic marker_pair_input_n_i,
    // serial configuration port read-out
    input wire logic spi_read_active_i,
    input wire logic spi_read_bit_i,
    output logic serial_port_read_out_o,
    output logic serial_port_read_out_oe_o,
    // sample stream
    input wire logic [`LST_SAMPLE_W-1:0] sample_i,
    input wire logic sample_valid_i,
    output logic [`LST_SAMPLE_W-1:0] sample_o,
    output logic sample_valid_o,
    output logic sample_mark_o,
    // link sequencing
    output logic sync_request_o,
    output lst_pkg::lst_link_state_t link_state_o,
    output logic cgs_active_o,
    output logic ilas_active_o,
    output logic ilas_start_o,
    output logic link_up_o,
    output logic nco_sync_o
);

    ////////////////////////////////////////////////////////////////////
    // marker pair receiver and sync source select

    // differential level: high when the positive leg is above the negative
    function automatic logic diff_level(input logic p, input logic n);
        diff_level = p & ~n;
    endfunction

    logic marker_level;
    logic marker_usable;
    lst_sync_if sync_bus ();

    always_comb begin
        marker_usable = marker_pair_receiver_enable_i;
        marker_level = marker_usable &
            diff_level(marker_pair_input_p_i, marker_pair_input_n_i);
        if (sync_sel_i) begin
            // disabled receiver reads as idle, never as a request
            sync_bus.level_n_raw = marker_usable ?
                marker_level : `LST_SYNC_IDLE;
        end else begin
            sync_bus.level_n_raw = single_ended_sync_pin_n_i;
        end
    end

    lst_sync2 u_sync (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .port_s(sync_bus.sync)
    );

    logic sync_low;
    assign sync_low = ~sync_bus.level_n_sync;

    ////////////////////////////////////////////////////////////////////
    // serial port read-out pin

    logic sdo_bit;
    logic next_sdo_bit;

    always_comb begin
        next_sdo_bit = spi_read_active_i ? spi_read_bit_i : `LST_RST_BIT;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_bit <= `LST_RST_BIT;
        end else begin
            sdo_bit <= next_sdo_bit;
        end
    end

    assign serial_port_read_out_o = sdo_bit;
    assign serial_port_read_out_oe_o = spi_read_active_i;

    ////////////////////////////////////////////////////////////////////
    // link start state machine

    lst_pkg::lst_link_state_t state;
    lst_pkg::lst_link_state_t next_state;
    logic [`LST_ILAS_W-1:0] ilas_cnt;
    logic [`LST_ILAS_W-1:0] next_ilas_cnt;
    logic ilas_start;
    logic next_ilas_start;

    always_comb begin
        next_state = state;
        next_ilas_cnt = ilas_cnt;
        next_ilas_start = 1'b0;
        if (mode_64b66b_i) begin
            // no handshake: the link runs regardless of the request
            next_state = lst_pkg::st_data;
            next_ilas_cnt = `LST_RST_CNT;
        end else begin
            unique case (state)
                lst_pkg::st_idle: begin
                    if (sync_low) begin
                        next_state = lst_pkg::st_cgs;
                    end
                end
                lst_pkg::st_cgs: begin
                    if (!sync_low) begin
                        next_state = lst_pkg::st_ilas;
                        next_ilas_cnt = `LST_ILAS_LEN - 8'h01;
                        next_ilas_start = 1'b1;
                    end
                end
                lst_pkg::st_ilas: begin
                    if (sync_low) begin
                        next_state = lst_pkg::st_cgs;
                    end else if (ilas_cnt == `LST_RST_CNT) begin
                        next_state = lst_pkg::st_data;
                    end else begin
                        next_ilas_cnt = ilas_cnt - 8'h01;
                    end
                end
                lst_pkg::st_data: begin
                    if (sync_low) begin
                        next_state = lst_pkg::st_cgs;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= lst_pkg::st_idle;
            ilas_cnt <= `LST_RST_CNT;
            ilas_start <= `LST_RST_BIT;
        end else begin
            state <= next_state;
            ilas_cnt <= next_ilas_cnt;
            ilas_start <= next_ilas_start;
        end
    end

    assign link_state_o = state;
    assign cgs_active_o = (state == lst_pkg::st_cgs);
    assign ilas_active_o = (state == lst_pkg::st_ilas);
    assign link_up_o = (state == lst_pkg::st_data);
    assign ilas_start_o = ilas_start;
    assign sync_request_o = sync_low;

    ////////////////////////////////////////////////////////////////////
    // nco sync trigger in 64b/66b

    logic sync_low_d;
    logic nco_sync;
    logic next_sync_low_d;
    logic next_nco_sync;

    always_comb begin
        next_sync_low_d = sync_low;
        next_nco_sync = mode_64b66b_i & sync_low & ~sync_low_d;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_low_d <= `LST_RST_BIT;
            nco_sync <= `LST_RST_BIT;
        end else begin
            sync_low_d <= next_sync_low_d;
            nco_sync <= next_nco_sync;
        end
    end

    assign nco_sync_o = nco_sync;

    ////////////////////////////////////////////////////////////////////
    // sample marking

    logic [`LST_SAMPLE_W-1:0] sample_q;
    logic sample_valid_q;
    logic sample_mark_q;
    logic [`LST_SAMPLE_W-1:0] next_sample_q;
    logic next_sample_valid_q;
    logic next_sample_mark_q;

    // the marker is read independently of the sync select, so one pair can
    // carry the request and be echoed in the sample stream at once
    always_comb begin
        next_sample_q = sample_valid_i ? sample_i : sample_q;
        next_sample_valid_q = sample_valid_i;
        next_sample_mark_q = sample_valid_i & sample_mark_enable_i &
            marker_level;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_q <= `LST_RST_SAMPLE;
            sample_valid_q <= `LST_RST_BIT;
            sample_mark_q <= `LST_RST_BIT;
        end else begin
            sample_q <= next_sample_q;
            sample_valid_q <= next_sample_valid_q;
            sample_mark_q <= next_sample_mark_q;
        end
    end

    assign sample_o = sample_q;
    assign sample_valid_o = sample_valid_q;
    assign sample_mark_o = sample_mark_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    // sampled nrst_i keeps attempts off the release edge, which still resets
    sdo_idle_hiz_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        !spi_read_active_i |-> !serial_port_read_out_oe_o)
    else $error("read-out pin driven outside a read");

    sdo_read_data_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        nrst_i && spi_read_active_i
        |=> serial_port_read_out_o == $past(spi_read_bit_i))
    else $error("read-out bit does not follow read data");

    se_sync_path_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (nrst_i && !sync_sel_i && !single_ended_sync_pin_n_i) [*3]
        |-> sync_low)
    else $error("single-ended sync request not seen");

    hi_speed_run_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (nrst_i && mode_64b66b_i) [*2] |-> state == lst_pkg::st_data)
    else $error("64b/66b link held by sync");

    cgs_entry_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (!mode_64b66b_i && sync_low && state != lst_pkg::st_cgs)
        |=> state == lst_pkg::st_cgs)
    else $error("sync request did not start code group sync");

    ilas_entry_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (!mode_64b66b_i && !sync_low && state == lst_pkg::st_cgs)
        |=> (state == lst_pkg::st_ilas && ilas_start_o)
        ##1 !ilas_start_o)
    else $error("sync release did not start alignment sequence");

    pair_sync_path_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (nrst_i && sync_sel_i && marker_pair_receiver_enable_i &&
        !marker_pair_input_p_i && marker_pair_input_n_i) [*3] |-> sync_low)
    else $error("marker pair sync request not seen");

    pair_active_low_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (sync_sel_i && marker_pair_receiver_enable_i &&
        marker_pair_input_p_i && !marker_pair_input_n_i) [*3] |-> !sync_low)
    else $error("marker pair high read as a request");

    sample_mark_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (nrst_i && sample_valid_i && sample_mark_enable_i &&
        marker_pair_receiver_enable_i &&
        diff_level(marker_pair_input_p_i, marker_pair_input_n_i))
        |=> sample_mark_o && sample_valid_o)
    else $error("asserted marker did not flag the sample");

    rx_off_ignore_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (!marker_pair_receiver_enable_i) |=> !sample_mark_o)
    else $error("disabled marker pair flagged a sample");

    rx_off_no_sync_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        (sync_sel_i && !marker_pair_receiver_enable_i) [*3] |-> !sync_low)
    else $error("disabled marker pair raised a sync request");

endmodule // lst_top

// ===== design/lst_cfg.svh
// constants for the link sync and sample marker block
`ifndef LST_CFG_SVH
`define LST_CFG_SVH

// sample path width
`define LST_SAMPLE_W 12

// idle level of an active-low sync request
`define LST_SYNC_IDLE 1'b1

// length of the lane alignment sequence, in clock cycles
`define LST_ILAS_W 8
`define LST_ILAS_LEN 8'h40

// reset values
`define LST_RST_BIT 1'b0
`define LST_RST_SAMPLE 12'h000
`define LST_RST_CNT 8'h00

`endif

// ===== design/lst_pkg.sv
// types of the link sync and sample marker block
package lst_pkg;

    // link states, gray coded along idle, cgs, ilas, data
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_cgs = 2'b01,
        st_ilas = 2'b11,
        st_data = 2'b10
    } lst_link_state_t;

endpackage

// ===== design/lst_sync_if.sv
// carrier between the sync selector and its synchroniser
`timescale 1ns/1ps
interface lst_sync_if;
    logic level_n_raw;
    logic level_n_sync;

    modport src (
        output level_n_raw,
        input level_n_sync
    );

    modport sync (
        input level_n_raw,
        output level_n_sync
    );
endinterface

// ===== design/lst_sync2.sv
// two-stage synchroniser for the active-low sync request
`timescale 1ns/1ps
`include "lst_cfg.svh"
module lst_sync2 (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // request level in and out
    lst_sync_if.sync port_s
);

    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    always_comb begin
        next_stage1 = port_s.level_n_raw;
        next_stage2 = stage1;
    end

    // both stages rest at the idle level, so reset asks for nothing
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage1 <= `LST_SYNC_IDLE;
            stage2 <= `LST_SYNC_IDLE;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign port_s.level_n_sync = stage2;

    // skip the two edges after release, whose stages still hold reset values
    sync_delay_a: assert property (
        @(posedge clock_i) disable iff (!nrst_i)
        $past(nrst_i) && $past(nrst_i, 2) |->
        port_s.level_n_sync == $past(port_s.level_n_raw, 2))
    else $error("sync request not delayed by two stages");

endmodule // lst_sync2

// ===== test/lst_rx_model.sv
// receiver-side model that drives the active-low sync request
`timescale 1ns/1ps
module lst_rx_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // control from the bench
    input wire logic req_i,
    input wire logic free_i,
    input wire logic [7:0] hold_i,
    // link status seen by the receiver
    input wire logic cgs_active_i,
    // sync request line
    output logic sync_n_o
);
    logic [7:0] cnt;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_n_o <= 1'b1;
            cnt <= 8'h00;
        end else if (req_i) begin
            sync_n_o <= 1'b0;
            cnt <= 8'h00;
        end else if (!sync_n_o && (cgs_active_i || free_i)) begin
            cnt <= cnt + 8'h01;
            if (cnt >= hold_i) begin
                sync_n_o <= 1'b1;
            end
        end
    end
endmodule // lst_rx_model

// ===== test/test_lst_top.sv
// self-checking bench for the link sync and sample marker block
`timescale 1ns/1ps
module test_lst_top;
    logic clock_i, nrst_i, sel, mode, rxen, men, rx_req, free, rx_n;
    logic spi_act, spi_bit, sval, rnd_p, rnd_n, mp, mn, pin_n, raw, req;
    logic [11:0] sdat, smp_o, m_smp;
    logic [7:0] hold;
    logic rd_o, oe_o, val_o, mark_o, rq_o, cgs_o, ilas_o, st_o, up_o, nco_o;
    lst_pkg::lst_link_state_t state_o;
    logic m_s1, m_s2, m_rd, m_nco, m_out, m_val, m_mark, m_ilas;
    logic [1:0] m_st;
    int m_cnt;
    integer seed = 89;
    int n_mismatch = 0;
    int samples_checked = 0;

    assign pin_n = sel ? 1'b0 : rx_n;
    assign mp = sel ? rx_n : rnd_p;
    assign mn = sel ? ~rx_n : rnd_n;
    assign raw = sel ? (rxen ? (mp & ~mn) : 1'b1) : pin_n;
    assign req = ~m_s2;

    lst_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .sync_sel_i(sel),
        .mode_64b66b_i(mode), .marker_pair_receiver_enable_i(rxen),
        .sample_mark_enable_i(men), .single_ended_sync_pin_n_i(pin_n),
        .marker_pair_input_p_i(mp), .marker_pair_input_n_i(mn),
        .spi_read_active_i(spi_act), .spi_read_bit_i(spi_bit),
        .serial_port_read_out_o(rd_o), .serial_port_read_out_oe_o(oe_o),
        .sample_i(sdat), .sample_valid_i(sval), .sample_o(smp_o),
        .sample_valid_o(val_o), .sample_mark_o(mark_o),
        .sync_request_o(rq_o), .link_state_o(state_o), .cgs_active_o(cgs_o),
        .ilas_active_o(ilas_o), .ilas_start_o(st_o), .link_up_o(up_o),
        .nco_sync_o(nco_o));

    lst_rx_model rx (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(rx_req),
        .free_i(free), .hold_i(hold), .cgs_active_i(cgs_o),
        .sync_n_o(rx_n));

    ////////////////////////////////////////////////////////////////////////
    // reference model
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {m_s1, m_s2} <= 2'b11;
            {m_rd, m_nco, m_out, m_val, m_mark, m_ilas} <= 6'h00;
            m_smp <= 12'h000;
            m_st <= 2'b00;
            m_cnt <= 0;
        end else begin
            m_s1 <= raw;
            m_s2 <= m_s1;
            m_rd <= req;
            m_nco <= mode & req & ~m_rd;
            m_out <= spi_act & spi_bit;
            m_val <= sval;
            if (sval) begin
                m_smp <= sdat;
            end
            m_mark <= sval & men & rxen & mp & ~mn;
            m_ilas <= !mode && m_st == 2'b01 && !req;
            if (mode) begin
                m_st <= 2'b10;
            end else if (req) begin
                m_st <= 2'b01;
            end else if (m_st == 2'b01) begin
                m_st <= 2'b11;
                m_cnt <= 63;
            end else if (m_st == 2'b11) begin
                if (m_cnt == 0) begin
                    m_st <= 2'b10;
                end
                m_cnt <= m_cnt - 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    task automatic chk(input string nm, input logic [11:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(negedge clock_i) begin
        if (nrst_i) begin
            chk("req", 12'(rq_o), 12'(req));
            chk("state", 12'(state_o), 12'(m_st));
            chk("cgs", 12'(cgs_o), 12'(m_st == 2'b01));
            chk("ilas", 12'(ilas_o), 12'(m_st == 2'b11));
            chk("start", 12'(st_o), 12'(m_ilas));
            chk("up", 12'(up_o), 12'(m_st == 2'b10));
            chk("nco", 12'(nco_o), 12'(m_nco));
            chk("oe", 12'(oe_o), 12'(spi_act));
            chk("rdout", 12'(rd_o), 12'(m_out));
            chk("valid", 12'(val_o), 12'(m_val));
            chk("mark", 12'(mark_o), 12'(m_mark));
            chk("sample", smp_o, m_smp);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stimulus
    task automatic wait_for(input logic want_ilas);
        int k;
        k = 0;
        while ((want_ilas ? ilas_o : up_o) !== 1'b1 && k < 300) begin
            @(posedge clock_i);
            k++;
        end
        if (k >= 300) begin
            chk("wait", 12'h000, 12'h001);
            complete_run;
        end
    endtask

    task automatic pulse_req;
        @(posedge clock_i);
        rx_req <= 1'b1;
        @(posedge clock_i);
        rx_req <= 1'b0;
    endtask

    always @(posedge clock_i) begin
        {rnd_p, rnd_n, spi_act, spi_bit, sval, sdat} <= 17'($random(seed));
    end

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    initial begin
        {nrst_i, sel, mode, rxen, men, rx_req, free} = 7'h00;
        {rnd_p, rnd_n, spi_act, spi_bit, sval} = 5'h00;
        sdat = 12'h000;
        hold = 8'h00;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            @(posedge clock_i);
            {sel, rxen, mode} <= 3'(c);
            men <= c[0] ^ c[1];
            free <= c[0];
            hold <= 8'(c * 9);
            if (c == 4) begin
                nrst_i <= 1'b0;
                repeat (2) @(posedge clock_i);
                nrst_i <= 1'b1;
            end
            pulse_req();
            if (!c[0] && (!c[2] || c[1])) begin
                wait_for(1'b1);
                repeat (c * 7 + 1) @(posedge clock_i);
                pulse_req();
                wait_for(1'b0);
                repeat (20) @(posedge clock_i);
            end else begin
                repeat (100) @(posedge clock_i);
            end
        end
        complete_run;
    end
endmodule // test_lst_top
